// ---- design/freefall_motion_defs.svh ----
`ifndef FREEFALL_MOTION_DEFS_SVH
`define FREEFALL_MOTION_DEFS_SVH

`define ADDR_CONFIG      8'h15
`define ADDR_SOURCE      8'h16
`define ADDR_THRESHOLD   8'h17
`define ADDR_DEBOUNCE    8'h18

`define CFG_LATCH_BIT    7
`define CFG_SELECT_BIT   6
`define CFG_Z_BIT        5
`define CFG_X_BIT        3

`define THS_MODE_BIT     7
`define THS_MSB          6

`define SRC_EA_BIT       7

`define CONFIG_RESET     8'h00
`define THRESHOLD_RESET  8'h00
`define DEBOUNCE_RESET   8'h00
`define RDATA_RESET      8'h00

`endif

// ---- design/freefall_motion_pkg.sv ----
package freefall_motion_pkg;

  typedef enum logic [1:0] {
    RT_FREEFALL      = 2'b00,
    RT_MOTION        = 2'b01,
    LATCHED_FREEFALL = 2'b10,
    LATCHED_MOTION   = 2'b11
  } mode_type;

endpackage

// ---- design/freefall_motion_detector.sv ----
// Operation
// - Select bit 0 gives freefall detection, 1 gives motion detection.
// - All three axis enables zero disables the whole detector.
// - Latch enable and select bit give four modes.
// - Real-time freefall raises event active after debounce, enabled axes only.
// - Real-time, debounce mode 0: flag holds until counter decrements away.
// - Real-time freefall, mode 1: clear at once, re-set only after delay.
// - Real-time freefall: reading source leaves event active unchanged.
// - Real-time: axis flags follow undebounced high-g comparison directly.
// - Latched freefall: event active set at count, held until source read.
// - Latched freefall: source read clears flag and counter; full delay again.
// - Latched freefall: axis flags follow while idle, frozen once set.
// - Real-time motion: set after debounce; mode 1 clears when high-g ends.
// - Real-time motion: source read clears nothing, counter untouched.
// - Latched motion: held until read; read clears all source bits, counter.
// - Latched motion: axis flags frozen while event active is set.
// - Config holds latch, select, Z/Y/X enables; bits 2..0 read zero.
// - Unsigned 7-bit threshold; freefall at or below, motion above.
// - Source: event active bit 7, Z/Y/X flag and polarity pairs below.
// - Debounce mode 0 decrements counter, 1 clears it, on false condition.
// - Axis flag and polarity read zero while that axis is disabled.
`timescale 1ns/1ps
`include "freefall_motion_defs.svh"

module freefall_motion_detector
  import freefall_motion_pkg::*;
#(
  parameter int AXIS_W  = 8,
  parameter int COUNT_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic              sample_valid,
  input  wire logic [AXIS_W-1:0] accel_x,
  input  wire logic [AXIS_W-1:0] accel_y,
  input  wire logic [AXIS_W-1:0] accel_z,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [7:0]        reg_rdata,
  output logic                   event_active
);

  logic               latch_enable;
  logic               or_and_select;
  logic [2:0]         axis_enable;
  logic               debounce_mode;
  logic [6:0]         threshold;
  logic [COUNT_W-1:0] debounce_count_value;
  logic [COUNT_W-1:0] count;
  logic [2:0]         high_flag;
  logic [2:0]         polarity;
  logic [COUNT_W-1:0] next_count;
  logic               next_active;
  logic [2:0]         next_high_flag;
  logic [2:0]         next_polarity;
  logic [AXIS_W-1:0]  axis_data [3];
  logic [2:0]         axis_above;
  logic [2:0]         axis_sign;
  logic               detector_on;
  logic               condition;
  logic               source_read;
  logic               read_clear;
  logic               base_active;
  logic [COUNT_W-1:0] base_count;
  logic [7:0]         source_value;
  logic [5:0]         axis_bits;
  mode_type           mode;

  assign axis_data[0] = accel_x;
  assign axis_data[1] = accel_y;
  assign axis_data[2] = accel_z;

  // Magnitude is taken from the two's complement sample on every axis.
  for (genvar i = 0; i < 3; i++) begin : g_axis
    logic [AXIS_W-1:0] magnitude;
    assign axis_sign[i]  = axis_data[i][AXIS_W-1];
    assign magnitude     = axis_sign[i] ? (~axis_data[i] + 1'b1)
                                        : axis_data[i];
    assign axis_above[i] = magnitude >
                           {{(AXIS_W-7){1'b0}}, threshold};
  end

  assign mode        = mode_type'({latch_enable, or_and_select});
  assign detector_on = |axis_enable;
  // Freefall needs every enabled axis low; motion needs any enabled high.
  assign condition   = or_and_select ? |(axis_above & axis_enable)
                                     : &(~axis_above | ~axis_enable);
  assign source_read = reg_read && (reg_addr == `ADDR_SOURCE);
  // Only latched modes clear on read; real-time reads are side-effect free.
  assign read_clear  = latch_enable && source_read;
  assign base_active = read_clear ? 1'b0 : event_active;
  assign base_count  = read_clear ? '0 : count;

  always_comb begin
    next_count     = base_count;
    next_active    = base_active;
    next_high_flag = read_clear ? 3'b000 : high_flag;
    next_polarity  = read_clear ? 3'b000 : polarity;
    if (!detector_on) begin
      next_count     = '0;
      next_active    = 1'b0;
      next_high_flag = 3'b000;
      next_polarity  = 3'b000;
    end else if (sample_valid) begin
      // The counter saturates at the programmed count, so a long event
      // can never wrap it back below the set point.
      case (mode)
        RT_FREEFALL: begin
          next_high_flag = axis_above & axis_enable;
          next_polarity  = axis_sign & axis_enable;
          if (condition) begin
            if (base_count < debounce_count_value) begin
              next_count = base_count + 1'b1;
            end
            if (next_count >= debounce_count_value) begin
              next_active = 1'b1;
            end
          end else if (debounce_mode) begin
            next_count  = '0;
            next_active = 1'b0;
          end else begin
            if (base_count != '0) begin
              next_count = base_count - 1'b1;
            end
            if (next_count == '0) begin
              next_active = 1'b0;
            end
          end
        end

        RT_MOTION: begin
          next_high_flag = axis_above & axis_enable;
          next_polarity  = axis_sign & axis_enable;
          if (condition) begin
            if (base_count < debounce_count_value) begin
              next_count = base_count + 1'b1;
            end
            if (next_count >= debounce_count_value) begin
              next_active = 1'b1;
            end
          end else if (debounce_mode) begin
            next_count  = '0;
            next_active = 1'b0;
          end else begin
            if (base_count != '0) begin
              next_count = base_count - 1'b1;
            end
            if (next_count == '0) begin
              next_active = 1'b0;
            end
          end
        end

        // Once the flag is up in a latched mode, counter and axis flags
        // freeze until a source read, a config write leaving latched mode, or all axes disabled.
        LATCHED_FREEFALL: begin
          if (!base_active) begin
            next_high_flag = axis_above & axis_enable;
            next_polarity  = axis_sign & axis_enable;
            if (condition) begin
              if (base_count < debounce_count_value) begin
                next_count = base_count + 1'b1;
              end
              if (next_count >= debounce_count_value) begin
                next_active = 1'b1;
              end
            end else if (debounce_mode) begin
              next_count = '0;
            end else if (base_count != '0) begin
              next_count = base_count - 1'b1;
            end
          end
        end

        LATCHED_MOTION: begin
          if (!base_active) begin
            next_high_flag = axis_above & axis_enable;
            next_polarity  = axis_sign & axis_enable;
            if (condition) begin
              if (base_count < debounce_count_value) begin
                next_count = base_count + 1'b1;
              end
              if (next_count >= debounce_count_value) begin
                next_active = 1'b1;
              end
            end else if (debounce_mode) begin
              next_count = '0;
            end else if (base_count != '0) begin
              next_count = base_count - 1'b1;
            end
          end
        end

        default: begin
          next_count = base_count;
        end
      endcase
    end
  end

  // A read that clears and a sample in the same cycle apply the clear first and then
  // count the sample from zero, so it sets the flag only if the debounce count is 1 or less.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      event_active <= 1'b0;
    end else begin
      event_active <= next_active;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      high_flag <= 3'b000;
    end else begin
      high_flag <= next_high_flag;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      polarity <= 3'b000;
    end else begin
      polarity <= next_polarity;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      latch_enable  <= 1'(`CONFIG_RESET >> `CFG_LATCH_BIT);
      or_and_select <= 1'b0;
      axis_enable   <= 3'b000;
    end else if (reg_write && reg_addr == `ADDR_CONFIG) begin
      latch_enable  <= reg_wdata[`CFG_LATCH_BIT];
      or_and_select <= reg_wdata[`CFG_SELECT_BIT];
      axis_enable   <= reg_wdata[`CFG_Z_BIT:`CFG_X_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      debounce_mode <= 1'b0;
      threshold     <= 7'(`THRESHOLD_RESET);
    end else if (reg_write && reg_addr == `ADDR_THRESHOLD) begin
      debounce_mode <= reg_wdata[`THS_MODE_BIT];
      threshold     <= reg_wdata[`THS_MSB:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      debounce_count_value <= COUNT_W'(`DEBOUNCE_RESET);
    end else if (reg_write && reg_addr == `ADDR_DEBOUNCE) begin
      debounce_count_value <= COUNT_W'(reg_wdata);
    end
  end

  // Masking again at readout keeps disabled axes at zero even after a
  // config write that lands while flags are frozen.
  for (genvar j = 0; j < 3; j++) begin : g_source
    assign axis_bits[2*j+1] = high_flag[j] & axis_enable[j];
    assign axis_bits[2*j]   = polarity[j] & axis_enable[j];
  end

  assign source_value = {event_active, 1'b0, axis_bits};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `RDATA_RESET;
    end else if (reg_read) begin
      case (reg_addr)
        `ADDR_CONFIG: begin
          reg_rdata <= {latch_enable, or_and_select, axis_enable,
                        3'b000};
        end
        `ADDR_SOURCE: begin
          reg_rdata <= source_value;
        end
        `ADDR_THRESHOLD: begin
          reg_rdata <= {debounce_mode, threshold};
        end
        `ADDR_DEBOUNCE: begin
          reg_rdata <= 8'(debounce_count_value);
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

endmodule

// ---- tb/freefall_motion_detector_asserts.sv ----
`timescale 1ns/1ps
module freefall_motion_checker (
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       sample_valid,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       event_active
);
  logic [7:0] cfg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n) cfg <= 8'h00;
    else if (reg_write && reg_addr == 8'h15) cfg <= reg_wdata;
  sequence s_src_rd; reg_read && reg_addr == 8'h16; endsequence
  sequence s_cfg_rd; reg_read && reg_addr == 8'h15; endsequence
  sequence s_bare_rd; s_src_rd ##0 !sample_valid && !reg_write; endsequence
  sequence s_nop; !reg_read && !reg_write && !sample_valid; endsequence
  property p_cfg; s_cfg_rd |=> reg_rdata == ($past(cfg) & 8'hF8); endproperty
  property p_ea; s_src_rd |=> reg_rdata[7] == $past(event_active); endproperty
  property p_z; s_src_rd ##0 !cfg[5] |=> reg_rdata[5:4] == 2'h0; endproperty
  property p_off; cfg[5:3] == 3'h0 |=> !event_active; endproperty
  property p_rt; !cfg[7] ##0 s_bare_rd |=> $stable(event_active); endproperty
  property p_lc; cfg[7] ##0 s_bare_rd |=> !event_active; endproperty
  property p_lh; cfg[7] && event_active ##0 s_nop |=> event_active; endproperty
  property p_idle; s_nop |=> $stable(event_active); endproperty
  a_cfg: assert property (p_cfg)
    else $error("bad cfg read");
  a_ea: assert property (p_ea)
    else $error("bad flag read");
  a_z: assert property (p_z)
    else $error("bad z bits");
  a_off: assert property (p_off)
    else $error("flag while off");
  a_rt: assert property (p_rt)
    else $error("read changed flag");
  a_lc: assert property (p_lc)
    else $error("flag kept");
  a_lh: assert property (p_lh)
    else $error("flag lost");
  a_idle: assert property (p_idle)
    else $error("flag moved");
endmodule
bind freefall_motion_detector freefall_motion_checker u_chk (.*);

// ---- tb/freefall_motion_detector_test.sv ----
`timescale 1ns/1ps
module freefall_motion_detector_test;
  logic       clk_sys, arst_n, sample_valid, reg_write, reg_read, event_active;
  logic [7:0] accel_x, accel_y, accel_z, reg_addr, reg_wdata, reg_rdata;
  int         error_cnt, compares;
  freefall_motion_detector u_dut (
    .clk_sys      (clk_sys),
    .arst_n       (arst_n),
    .sample_valid (sample_valid),
    .accel_x      (accel_x),
    .accel_y      (accel_y),
    .accel_z      (accel_z),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_write    (reg_write),
    .reg_read     (reg_read),
    .reg_rdata    (reg_rdata),
    .event_active (event_active)
  );
  initial forever #5 clk_sys = ~clk_sys;
  task wrap_up(input int hang);
    error_cnt += hang;
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    error_cnt += int'(seen !== exp);
    if (seen !== exp)
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
  endtask
  task acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_sys);
    {reg_addr, reg_wdata, reg_write, reg_read} = {a, d, w, !w};
    @(negedge clk_sys);
    {reg_write, reg_read} = 2'h0;
    if (!w) chk(reg_rdata, d);
  endtask
  task smp(input logic [23:0] xyz, input logic e);
    @(negedge clk_sys);
    {accel_x, accel_y, accel_z, sample_valid} = {xyz, 1'b1};
    @(negedge clk_sys);
    sample_valid = 1'b0;
    chk({7'h00, event_active}, {7'h00, e});
  endtask
  // All axes are disabled first, which clears any count left by a mode.
  task setup(input logic [7:0] c, input logic [7:0] t, input logic [7:0] n);
    acc(8'h15, 8'h00, 1'b1);
    acc(8'h17, t, 1'b1);
    acc(8'h18, n, 1'b1);
    acc(8'h15, c | 8'h07, 1'b1);
    acc(8'h15, c & 8'hF8, 1'b0);
  endtask
  task t_rt_motion();
    setup(8'h78, 8'h90, 8'h02);
    smp(24'h200000, 1'b0);
    smp(24'h200000, 1'b1);
    acc(8'h16, 8'h82, 1'b0);
    smp(24'h1010F0, 1'b0);
    acc(8'h30, 8'h00, 1'b0);
  endtask
  task t_rt_freefall();
    setup(8'h08, 8'h10, 8'h02);
    smp(24'h107F81, 1'b0);
    smp(24'h007F81, 1'b1);
    acc(8'h16, 8'h80, 1'b0);
    smp(24'h300000, 1'b1);
    smp(24'hD00000, 1'b0);
  endtask
  task t_latched_motion();
    setup(8'hF8, 8'h90, 8'h02);
    smp(24'hE00000, 1'b0);
    smp(24'h200000, 1'b1);
    smp(24'h0000E0, 1'b1);
    acc(8'h16, 8'h82, 1'b0);
    acc(8'h16, 8'h00, 1'b0);
    smp(24'h0000E0, 1'b0);
    smp(24'h0000E0, 1'b1);
    acc(8'h16, 8'hB0, 1'b0);
  endtask
  task t_latched_freefall();
    setup(8'hB8, 8'h10, 8'h01);
    smp(24'h000000, 1'b1);
    smp(24'h200000, 1'b1);
    acc(8'h16, 8'h80, 1'b0);
    acc(8'h16, 8'h00, 1'b0);
    smp(24'h200000, 1'b0);
    acc(8'h16, 8'h02, 1'b0);
  endtask
  initial begin
    {clk_sys, arst_n, sample_valid, reg_write, reg_read} = 5'h00;
    {accel_x, accel_y, accel_z, reg_addr, reg_wdata} = 40'h0;
    #40 arst_n = 1'b1;
    t_rt_motion();
    t_rt_freefall();
    t_latched_motion();
    t_latched_freefall();
    wrap_up(0);
  end
  initial #20000 wrap_up(1);
endmodule
